// ---- common/latch_params.svh ----
// Offsets, field positions and reset values of the latch input unit
`ifndef LATCH_PARAMS_SVH
`define LATCH_PARAMS_SVH

`define LT_CTRL_A_OFS   16'h09A8
`define LT_CTRL_B_OFS   16'h09A9
`define LT_FLAGS_A_OFS  16'h09AE
`define LT_FLAGS_B_OFS  16'h09AF
`define LT_RISE_A_OFS   16'h09B0
`define LT_FALL_A_OFS   16'h09B8
`define LT_RISE_B_OFS   16'h09C0
`define LT_FALL_B_OFS   16'h09C8

`define LT_RISE_BIT     0
`define LT_FALL_BIT     1
`define LT_PIN_BIT      2
`define LT_ASSIGN_A_BIT 4
`define LT_ASSIGN_B_BIT 5

`define LT_CTRL_RST     8'h00
`define LT_BYTE_ZERO    8'h00
`define LT_TS_RST       64'h0000_0000_0000_0000
`define LT_TS_W_DEFAULT 64

`endif

// ---- common/latch_pkg.sv ----
// Types shared by the latch input unit
`default_nettype none

package latch_pkg;

  typedef enum logic {
    MODE_CONTINUOUS = 1'b0,
    MODE_SINGLE     = 1'b1
  } capture_mode_t;

  typedef enum logic {
    OWNER_NETWORK = 1'b0,
    OWNER_HOST    = 1'b1
  } write_owner_t;

endpackage

`default_nettype wire

// ---- logic/edge_latch_unit.sv ----
// Edge detector, event flags and time capture for one latch input
`include "latch_params.svh"
`default_nettype none

module edge_latch_unit #(
  parameter int TS_W = `LT_TS_W_DEFAULT
) (
  input  wire logic                             core_clk,
  input  wire logic                             rst,
  input  wire logic                             pin,
  input  wire logic [TS_W-1:0]                  sys_time,
  input  wire latch_pkg::capture_mode_t [1:0]   mode,
  input  wire logic [1:0]                       clr,
  output logic                                  pin_level,
  output logic [1:0]                            flag,
  output logic [1:0][TS_W-1:0]                  ts
);
  import latch_pkg::*;

  logic [1:0] edge_det;
  logic [1:0] take;

  // Index 0 is the rising edge, index 1 the falling edge
  assign edge_det[0] = pin & ~pin_level;
  assign edge_det[1] = ~pin & pin_level;

  always_comb begin
    for (int e = 0; e < 2; e++) begin
      // A clear in the same cycle re-arms, so the new edge is kept
      take[e] = edge_det[e] && (mode[e] == MODE_CONTINUOUS || !flag[e] || clr[e]);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_level <= 1'b0;
    end else begin
      pin_level <= pin;
    end
  end

  always_ff @(posedge core_clk) begin
    for (int e = 0; e < 2; e++) begin
      if (rst) begin
        flag[e] <= 1'b0;
        ts[e]   <= TS_W'(`LT_TS_RST);
      end else begin
        if (take[e]) begin
          ts[e] <= sys_time;
        end
        if (mode[e] == MODE_CONTINUOUS) begin
          flag[e] <= 1'b0;
        end else if (take[e]) begin
          flag[e] <= 1'b1;
        end else if (clr[e]) begin
          flag[e] <= 1'b0;
        end
      end
    end
  end

  property p_single_hold;
    @(posedge core_clk) disable iff (rst)
      (mode[0] == MODE_SINGLE && flag[0] && !clr[0] && edge_det[0]) |=> $stable(ts[0]);
  endproperty
  a_single_hold: assert property (p_single_hold) else $error("Single mode overwrote rise time");

  property p_rise_capture;
    @(posedge core_clk) disable iff (rst)
      (mode[0] == MODE_CONTINUOUS && edge_det[0]) |=> ts[0] == $past(sys_time);
  endproperty
  a_rise_capture: assert property (p_rise_capture) else $error("Rise time not captured");

  property p_fall_capture;
    @(posedge core_clk) disable iff (rst)
      (pin_level && !pin && mode[1] == MODE_CONTINUOUS) |=> ts[1] == $past(sys_time);
  endproperty
  a_fall_capture: assert property (p_fall_capture) else $error("Fall time not captured");

  property p_flag_set;
    @(posedge core_clk) disable iff (rst)
      (mode[1] == MODE_SINGLE && edge_det[1] && !flag[1]) |=> flag[1] ##0 ts[1] == $past(sys_time);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("Single event flag not set");

  property p_flag_cont_zero;
    @(posedge core_clk) disable iff (rst)
      (mode[0] == MODE_CONTINUOUS) |=> !flag[0];
  endproperty
  a_flag_cont_zero: assert property (p_flag_cont_zero) else $error("Flag set in continuous mode");

  property p_flag_clear;
    @(posedge core_clk) disable iff (rst)
      (flag[0] && clr[0] && !edge_det[0]) |=> !flag[0];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("Read did not clear rise flag");

  property p_pin_level;
    @(posedge core_clk) disable iff (rst)
      1'b1 |=> pin_level == $past(pin);
  endproperty
  a_pin_level: assert property (p_pin_level) else $error("Pin level not followed");

  c_single_event: cover property (@(posedge core_clk) disable iff (rst)
    mode[0] == MODE_SINGLE && edge_det[0] ##1 flag[0] ##[1:20] clr[0]);
  c_set_and_clear: cover property (@(posedge core_clk) disable iff (rst)
    flag[1] && clr[1] && edge_det[1]);

endmodule // edge_latch_unit

`default_nettype wire

// ---- logic/event_timestamp_latch.sv ----
// Latch input unit: two inputs timestamped against system time, two byte register ports
`include "latch_params.svh"
`default_nettype none

module event_timestamp_latch #(
  parameter int TS_W = `LT_TS_W_DEFAULT
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             latch_input_a,
  input  wire logic             latch_input_b,
  input  wire logic [TS_W-1:0]  sys_time,
  input  wire logic [7:0]       access_assign,
  input  wire logic [15:0]      net_addr,
  input  wire logic             net_wr,
  input  wire logic             net_rd,
  input  wire logic [7:0]       net_wdata,
  output logic [7:0]            net_rdata,
  input  wire logic [15:0]      host_addr,
  input  wire logic             host_wr,
  input  wire logic             host_rd,
  input  wire logic [7:0]       host_wdata,
  output logic [7:0]            host_rdata
);
  import latch_pkg::*;

  localparam logic [15:0] CTRL_OFS  [2] = '{`LT_CTRL_A_OFS, `LT_CTRL_B_OFS};
  localparam logic [15:0] FLAGS_OFS [2] = '{`LT_FLAGS_A_OFS, `LT_FLAGS_B_OFS};
  localparam logic [15:0] TIME_OFS  [2][2] = '{'{`LT_RISE_A_OFS, `LT_FALL_A_OFS},
                                               '{`LT_RISE_B_OFS, `LT_FALL_B_OFS}};
  localparam int          ASSIGN_BIT [2] = '{`LT_ASSIGN_A_BIT, `LT_ASSIGN_B_BIT};

  capture_mode_t [1:0]        mode_r   [2];
  logic [1:0]                 flag     [2];
  logic [1:0]                 clr      [2];
  logic                       pin_lvl  [2];
  logic [1:0][TS_W-1:0]       ts       [2];
  logic                       pins     [2];

  assign pins[0] = latch_input_a;
  assign pins[1] = latch_input_b;

  // Any byte of an eight-byte time register counts as a hit
  function automatic logic time_hit(input logic [15:0] a, input int i, input int e);
    time_hit = (a[15:3] == TIME_OFS[i][e][15:3]);
  endfunction

  function automatic logic [7:0] reg_byte(input logic [15:0] a);
    logic [63:0] wide;
    reg_byte = `LT_BYTE_ZERO;
    for (int i = 0; i < 2; i++) begin
      if (a == CTRL_OFS[i]) begin
        reg_byte[`LT_RISE_BIT] = mode_r[i][0];
        reg_byte[`LT_FALL_BIT] = mode_r[i][1];
      end
      if (a == FLAGS_OFS[i]) begin
        reg_byte[`LT_RISE_BIT] = flag[i][0];
        reg_byte[`LT_FALL_BIT] = flag[i][1];
        reg_byte[`LT_PIN_BIT]  = pin_lvl[i];
      end
      for (int e = 0; e < 2; e++) begin
        if (time_hit(a, i, e)) begin
          // Bytes above the configured width read as zero
          wide     = 64'(ts[i][e]);
          reg_byte = wide[8*a[2:0] +: 8];
        end
      end
    end
  endfunction

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      for (int e = 0; e < 2; e++) begin
        clr[i][e] = (net_rd && time_hit(net_addr, i, e))
                 || (host_rd && time_hit(host_addr, i, e));
      end
    end
  end

  // Only the owning port may write; the other port's write is silently dropped
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 2; i++) begin
      if (rst) begin
        mode_r[i][0] <= MODE_CONTINUOUS;
        mode_r[i][1] <= MODE_CONTINUOUS;
      end else if (access_assign[ASSIGN_BIT[i]] == OWNER_NETWORK) begin
        if (net_wr && net_addr == CTRL_OFS[i]) begin
          mode_r[i][0] <= capture_mode_t'(net_wdata[`LT_RISE_BIT]);
          mode_r[i][1] <= capture_mode_t'(net_wdata[`LT_FALL_BIT]);
        end
      end else if (host_wr && host_addr == CTRL_OFS[i]) begin
        mode_r[i][0] <= capture_mode_t'(host_wdata[`LT_RISE_BIT]);
        mode_r[i][1] <= capture_mode_t'(host_wdata[`LT_FALL_BIT]);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      net_rdata <= `LT_BYTE_ZERO;
    end else if (net_rd) begin
      net_rdata <= reg_byte(net_addr);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      host_rdata <= `LT_BYTE_ZERO;
    end else if (host_rd) begin
      host_rdata <= reg_byte(host_addr);
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_input
    edge_latch_unit #(
      .TS_W (TS_W)
    ) u_unit (
      .core_clk  (core_clk),
      .rst       (rst),
      .pin       (pins[g]),
      .sys_time  (sys_time),
      .mode      (mode_r[g]),
      .clr       (clr[g]),
      .pin_level (pin_lvl[g]),
      .flag      (flag[g]),
      .ts        (ts[g])
    );
  end

  property p_write_gate_a;
    @(posedge core_clk) disable iff (rst)
      (access_assign[`LT_ASSIGN_A_BIT] && !(host_wr && host_addr == `LT_CTRL_A_OFS))
        |=> $stable(mode_r[0]);
  endproperty
  a_write_gate_a: assert property (p_write_gate_a) else $error("Unowned write changed ctrl a");

  property p_write_gate_b;
    @(posedge core_clk) disable iff (rst)
      (!access_assign[`LT_ASSIGN_B_BIT] && net_wr && net_addr == `LT_CTRL_B_OFS)
        |=> mode_r[1][1] == capture_mode_t'($past(net_wdata[`LT_FALL_BIT]));
  endproperty
  a_write_gate_b: assert property (p_write_gate_b) else $error("Owned write lost on ctrl b");

  property p_read_rise_b;
    @(posedge core_clk) disable iff (rst)
      (host_rd && host_addr == `LT_RISE_B_OFS) |=> host_rdata == $past(ts[1][0][7:0]);
  endproperty
  a_read_rise_b: assert property (p_read_rise_b) else $error("Wrong byte at rise time b");

  property p_read_fall_b;
    @(posedge core_clk) disable iff (rst)
      (net_rd && net_addr == `LT_FALL_B_OFS) |=> net_rdata == $past(ts[1][1][7:0]);
  endproperty
  a_read_fall_b: assert property (p_read_fall_b) else $error("Wrong byte at fall time b");

  property p_status_reserved;
    @(posedge core_clk) disable iff (rst)
      (net_rd && net_addr == `LT_FLAGS_A_OFS)
        |=> net_rdata[7:3] == 5'h00 && net_rdata[2] == $past(pin_lvl[0]);
  endproperty
  a_status_reserved: assert property (p_status_reserved) else $error("Bad status byte a");

  property p_read_clears_b;
    @(posedge core_clk) disable iff (rst)
      (flag[1][1] && net_rd && (net_addr & 16'hFFF8) == `LT_FALL_B_OFS && !pins[1] == !pin_lvl[1])
        |=> !flag[1][1];
  endproperty
  a_read_clears_b: assert property (p_read_clears_b) else $error("Fall flag b not cleared");

  property p_ctrl_read_a;
    @(posedge core_clk) disable iff (rst)
      (host_rd && host_addr == `LT_CTRL_A_OFS)
        |=> host_rdata[7:2] == 6'h00 && host_rdata[1:0] == $past(mode_r[0]);
  endproperty
  a_ctrl_read_a: assert property (p_ctrl_read_a) else $error("Bad control byte a");

  property p_ctrl_read_b;
    @(posedge core_clk) disable iff (rst)
      (net_rd && net_addr == `LT_CTRL_B_OFS)
        |=> net_rdata[7:2] == 6'h00 && net_rdata[1:0] == $past(mode_r[1]);
  endproperty
  a_ctrl_read_b: assert property (p_ctrl_read_b) else $error("Bad control byte b");

  // A flag may only show for an edge that is in single-event mode
  property p_flags_cont_b;
    @(posedge core_clk) disable iff (rst)
      (host_rd && host_addr == `LT_FLAGS_B_OFS)
        |=> (host_rdata[1:0] & ~$past(mode_r[1])) == 2'b00;
  endproperty
  a_flags_cont_b: assert property (p_flags_cont_b) else $error("Flag b shown in continuous mode");

  property p_read_clears_rise_a;
    @(posedge core_clk) disable iff (rst)
      (flag[0][0] && host_rd && (host_addr & 16'hFFF8) == `LT_RISE_A_OFS && pins[0] == pin_lvl[0])
        |=> !flag[0][0];
  endproperty
  a_read_clears_rise_a: assert property (p_read_clears_rise_a) else $error("Rise flag a kept");

  property p_read_clears_fall_a;
    @(posedge core_clk) disable iff (rst)
      (flag[0][1] && net_rd && (net_addr & 16'hFFF8) == `LT_FALL_A_OFS && pins[0] == pin_lvl[0])
        |=> !flag[0][1];
  endproperty
  a_read_clears_fall_a: assert property (p_read_clears_fall_a) else $error("Fall flag a kept");

  c_host_owner_write: cover property (@(posedge core_clk) disable iff (rst)
    access_assign[`LT_ASSIGN_A_BIT] && host_wr && host_addr == `LT_CTRL_A_OFS);
  c_both_read: cover property (@(posedge core_clk) disable iff (rst) net_rd && host_rd);
  c_host_clear_a: cover property (@(posedge core_clk) disable iff (rst)
    flag[0][0] && host_rd && host_addr == `LT_RISE_A_OFS);

endmodule // event_timestamp_latch

`default_nettype wire

// ---- tb/latch_pin_model.sv ----
// Model of the two external trigger sources on the latch pins
`default_nettype none

module latch_pin_model (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [1:0] want,
  output logic      [1:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pins change only at the falling edge so the block sees a settled level
  always @(negedge core_clk) begin
    pins <= rst ? 2'b00 : want;
  end

endmodule // latch_pin_model

`default_nettype wire

// ---- tb/event_timestamp_latch_tb.sv ----
// Self-checking bench of the latch input unit
`default_nettype none

module event_timestamp_latch_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [1:0]  want = 2'b00;
  logic [1:0]  pins;
  logic [63:0] sys_time = 64'h0000_0000_0000_0000;
  logic [7:0]  access_assign = 8'h00;
  logic [15:0] net_addr = 16'h0000, host_addr = 16'h0000;
  logic        net_wr = 1'b0, net_rd = 1'b0, host_wr = 1'b0, host_rd = 1'b0;
  logic [7:0]  net_wdata = 8'h00, host_wdata = 8'h00, net_rdata, host_rdata;
  logic [7:0]  qh[$], qn[$];
  logic        hp = 1'b0, np = 1'b0;
  logic [31:0] tseed = 32'hf8c7, rnd = 32'hf8c7;
  logic [63:0] t1, t2, t5;
  logic [7:0]  d;
  int          err_count = 0, checked = 0;

  event_timestamp_latch #(.TS_W(64)) dut (
    .core_clk(core_clk), .rst(rst), .latch_input_a(pins[0]), .latch_input_b(pins[1]),
    .sys_time(sys_time), .access_assign(access_assign),
    .net_addr(net_addr), .net_wr(net_wr), .net_rd(net_rd), .net_wdata(net_wdata),
    .net_rdata(net_rdata), .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
    .host_wdata(host_wdata), .host_rdata(host_rdata)
  );

  latch_pin_model pin_src (.core_clk(core_clk), .rst(rst), .want(want), .pins(pins));

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  always @(negedge core_clk) begin
    tseed = xs(tseed);
    sys_time <= {tseed, tseed ^ 32'h5a5a_5a5a};
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Read data lands one cycle after the strobe, so compare at the next falling edge
  always @(posedge core_clk) begin
    hp <= host_rd;
    np <= net_rd;
  end
  always @(negedge core_clk) begin
    if (hp) chk(host_rdata, qh.pop_front());
    if (np) chk(net_rdata, qn.pop_front());
  end

  task automatic rd(input bit p, input logic [15:0] a, input logic [7:0] e);
    @(negedge core_clk);
    if (p) begin
      host_addr = a;
      host_rd = 1'b1;
      qh.push_back(e);
    end else begin
      net_addr = a;
      net_rd = 1'b1;
      qn.push_back(e);
    end
    @(negedge core_clk);
    host_rd = 1'b0;
    net_rd = 1'b0;
  endtask

  task automatic wr(input bit p, input logic [15:0] a, input logic [7:0] v);
    @(negedge core_clk);
    if (p) begin
      host_addr = a;
      host_wdata = v;
      host_wr = 1'b1;
    end else begin
      net_addr = a;
      net_wdata = v;
      net_wr = 1'b1;
    end
    @(negedge core_clk);
    host_wr = 1'b0;
    net_wr = 1'b0;
  endtask

  // Time registers are little-endian bytes
  task automatic rd64(input bit p, input logic [15:0] a, input logic [63:0] e);
    for (int k = 0; k < 8; k++) rd(p, a + 16'(k), e[8*k +: 8]);
  endtask

  // Returns the system time that the block samples together with the new pin level
  task automatic edge_at(input int i, input logic v, output logic [63:0] t);
    @(posedge core_clk);
    #1 want[i] = v;
    @(negedge core_clk);
    #1 t = sys_time;
  endtask

  initial begin
    #100000;
    err_count++;
    end_of_test();
  end

  initial begin
    repeat (6) @(negedge core_clk);
    rst = 1'b0;
    rd(1, 16'h09A8, 8'h00);
    rd(1, 16'h09A9, 8'h00);
    rd(0, 16'h09AE, 8'h00);
    rd(0, 16'h09AF, 8'h00);
    for (int k = 0; k < 4; k++) rd64(k[0], 16'h09B0 + 16'(8 * k), 64'h0);
    rd(1, 16'h0990, 8'h00);
    // Each control byte is writable only from the port that its assignment bit selects
    for (int i = 0; i < 2; i++) begin
      rnd = xs(rnd);
      d = rnd[7:0];
      access_assign = 8'h00;
      wr(1, 16'h09A8 + 16'(i), d);
      rd(1, 16'h09A8 + 16'(i), 8'h00);
      wr(0, 16'h09A8 + 16'(i), d);
      rd(1, 16'h09A8 + 16'(i), d & 8'h03);
      access_assign = 8'h10 << i;
      wr(0, 16'h09A8 + 16'(i), 8'h00);
      rd(0, 16'h09A8 + 16'(i), d & 8'h03);
      wr(1, 16'h09A8 + 16'(i), 8'h00);
      rd(0, 16'h09A8 + 16'(i), 8'h00);
    end
    // Continuous capture on input a: later edges overwrite, no flags
    edge_at(0, 1'b1, t1);
    edge_at(0, 1'b0, t2);
    edge_at(0, 1'b1, t5);
    rd(1, 16'h09AE, 8'h04);
    rd64(0, 16'h09B0, t5);
    rd64(1, 16'h09B8, t2);
    // Single-event capture on input b: first edge kept until its flag is cleared
    access_assign = 8'h00;
    wr(0, 16'h09A9, 8'h03);
    edge_at(1, 1'b1, t1);
    edge_at(1, 1'b0, t2);
    edge_at(1, 1'b1, t5);
    edge_at(1, 1'b0, t5);
    rd(1, 16'h09AF, 8'h03);
    rd64(1, 16'h09C0, t1);
    rd(0, 16'h09AF, 8'h02);
    rd64(0, 16'h09C8, t2);
    rd(1, 16'h09AF, 8'h00);
    edge_at(1, 1'b1, t5);
    rd(0, 16'h09AF, 8'h05);
    rd64(1, 16'h09C0, t5);
    rd(1, 16'h09AE, 8'h04);
    // Single-event capture on input a; a read of any byte clears the flag
    wr(0, 16'h09A8, 8'h03);
    edge_at(0, 1'b0, t1);
    edge_at(0, 1'b1, t2);
    rd(1, 16'h09AE, 8'h07);
    rd(0, 16'h09BD, t1[47:40]);
    rd(1, 16'h09AE, 8'h05);
    rd64(1, 16'h09B0, t2);
    rd(0, 16'h09AE, 8'h04);
    repeat (3) @(negedge core_clk);
    end_of_test();
  end

endmodule // event_timestamp_latch_tb

`default_nettype wire
